// *** cmd_pkg.sv ***
package cmd_pkg;
   // link framing and rates
   localparam int unsigned clk_hz = 40_000_000;
   localparam int unsigned default_baud = 115_200;
   localparam int unsigned baud_div = clk_hz / default_baud;
   // sleep entry and wake settle times
   localparam int unsigned settle_ms = 10;
   localparam int unsigned settle_cycles = settle_ms * (clk_hz / 1000);
   // solution update interval
   localparam int unsigned fix_interval_ms = 1000;
   localparam int unsigned fix_cycles = fix_interval_ms * (clk_hz / 1000);
   // request character repeat interval while waiting for the first block
   localparam int unsigned poll_ms = 1000;
   localparam int unsigned poll_cycles = poll_ms * (clk_hz / 1000);
   // byte values
   localparam logic [7:0] crc_request_char = 8'h43;
   localparam logic [7:0] dle_byte = 8'h10;
   localparam logic [7:0] stx_byte = 8'h01;
   localparam logic [7:0] etx_byte = 8'h03;
   localparam logic [7:0] dollar_byte = 8'h24;
   localparam logic [7:0] lf_byte = 8'h0a;
   // xmodem control bytes
   localparam logic [7:0] xm_soh = 8'h01;
   localparam logic [7:0] xm_eot = 8'h04;
   localparam logic [7:0] xm_ack = 8'h06;
   localparam logic [7:0] xm_nak = 8'h15;
   localparam int unsigned xm_block_len = 133;
   // port protocols
   typedef enum logic [1:0]
   {
      proto_text = 2'b00,
      proto_binary = 2'b01,
      proto_corr = 2'b10
   } proto_e;
   // one received byte with its port of origin
   typedef struct packed
   {
      logic port;
      logic [7:0] data;
   } rx_byte_s;
endpackage : cmd_pkg

// *** host_command_sleep_fw_loader.sv ***
`timescale 1ns/1ps
// What this block does
// [RL1] port one carries text sentences at 115200 after reset
// [RL2] port two carries vendor binary protocol at 115200 after reset
// [RL3] on correction ports, text sentences inside the stream are still executed
// [RL4] host enables correction input before selecting that port's text output
// [RL5] solution updates and output messages are produced once per second
// [RL6] sleep request sentence with 1111 starts sleep entry
// [RL7] asleep: indicator low, radio chains and reference oscillator off
// [RL8] at least 10 ms pass after decoding before sleep is complete
// [RL9] any command on a receive line wakes the device
// [RL10] falling receive edge wakes; up to 10 ms to normal operation
// [RL11] host waits 10 ms after the wake edge before next command
// [RL12] host sends text reload request with R and checksum 2F
// [RL13] host sends binary reload framed by 10 01 and 10 03
// [RL14] either reload command enters programming mode and sends 0x43
// [RL15] host answers with the patch over xmodem with crc
// [RL16] after the whole patch arrives, store it and restart
// [RL17] flash writing starts after transfer ends; old patch erased first
// [RL18] only patches matching the mask rom version are stored
// [RL19] host keeps power and reset during flash writing
// [RL20] host sends only firmware families matching the hardware generation
// [RL21] clocks of unused subsystems are gated automatically
// [RL22] request character repeats until the first block arrives
module host_command_sleep_fw_loader
   import cmd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // decoded receive bytes from the two ports
   input wire logic rx_valid,
   input wire rx_byte_s rx_byte,
   output logic rx_ready,
   // raw receive lines for wake detection
   input wire logic [1:0] rx_line,
   // port configuration from the protocol handler
   input wire logic [1:0] corr_enable,
   // patch store answers
   input wire logic patch_version_ok,
   input wire logic flash_done,
   // transmit byte toward the host
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   // protocol and rate per port
   output proto_e port_proto [2],
   output logic [31:0] port_baud [2],
   // power control
   output logic sleep_flag,
   output logic rf_enable,
   output logic ref_osc_enable,
   output logic [2:0] unit_clk_en,
   // navigation tick and loader actions
   output logic fix_tick,
   output logic patch_byte_valid,
   output logic [7:0] patch_byte,
   output logic flash_erase,
   output logic flash_write,
   output logic restart
);

   typedef enum logic [3:0]
   {
      st_run = 4'b0000,
      st_sleep_wait = 4'b0001,
      st_asleep = 4'b0010,
      st_waking = 4'b0011,
      st_prog_poll = 4'b0100,
      st_prog_rx = 4'b0101,
      st_check = 4'b0110,
      st_erase = 4'b0111,
      st_write = 4'b1000,
      st_restart = 4'b1001
   } state_e;

   state_e state, next_state;
   logic [31:0] timer, next_timer;
   logic [31:0] fix_cnt, next_fix_cnt;
   logic [7:0] blk_cnt, next_blk_cnt;
   logic [7:0] match, next_match;
   logic [7:0] bmatch, next_bmatch;
   logic [7:0] smatch, next_smatch;
   logic [1:0] rx_prev;
   logic [7:0] next_tx_byte;
   logic tx_req;

   // two-entry buffer on the transmit path
   logic [7:0] buf_mem [2];
   logic buf_wr, buf_rd;
   logic [1:0] buf_cnt, next_buf_cnt;
   logic buf_wp, buf_rp, next_buf_wp, next_buf_rp;
   assign buf_wr = tx_req && (buf_cnt != 2'd2);
   assign buf_rd = tx_valid && tx_ready;
   assign tx_valid = (buf_cnt != 2'd0);
   assign tx_data = buf_mem[buf_rp];

   // buffer pointer update
   always_comb
   begin
      next_buf_wp = buf_wr ? ~buf_wp : buf_wp;
      next_buf_rp = buf_rd ? ~buf_rp : buf_rp;
      next_buf_cnt = buf_cnt + {1'b0, buf_wr} - {1'b0, buf_rd};
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         buf_wp <= 1'b0;
         buf_rp <= 1'b0;
         buf_cnt <= 2'd0;
      end
      else
      begin
         buf_wp <= next_buf_wp;
         buf_rp <= next_buf_rp;
         buf_cnt <= next_buf_cnt;
      end
      // the word is stored in the cycle it is asked for, so an ack is never swapped for 'C'
      if (buf_wr)
         buf_mem[buf_wp] <= next_tx_byte;
   end

   // default port setup: fixed rates, protocol set by the enable input
   // [RL4] correction mode comes only from the enable input
   always_comb
   begin
      // [RL1] text on port one
      port_proto[0] = corr_enable[0] ? proto_corr : proto_text;
      // [RL2] binary on port two
      port_proto[1] = corr_enable[1] ? proto_corr : proto_binary;
      port_baud[0] = default_baud;
      port_baud[1] = default_baud;
   end

   // byte acceptance: every byte is taken at once, even the loader never waits on transmit room
   assign rx_ready = 1'b1;
   logic rx_take;
   logic is_text;
   assign rx_take = rx_valid && rx_ready;
   // [RL3] text sentences are parsed on port one and on any port in correction mode
   assign is_text = rx_take && (rx_byte.port == 1'b0 || corr_enable[rx_byte.port]);

   // sentence matchers
   localparam logic [7:0] sleep_str [20] = '{8'h24, 8'h50, 8'h4f, 8'h50, 8'h57, 8'h52, 8'h2c,
      8'h31, 8'h31, 8'h31, 8'h31, 8'h2a, 8'h36, 8'h36, 8'h0d, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] sleep_len = 8'd16;
   localparam logic [7:0] rl_str [14] = '{8'h24, 8'h50, 8'h4f, 8'h50, 8'h52, 8'h4c, 8'h2c,
      8'h52, 8'h2a, 8'h32, 8'h46, 8'h0d, 8'h0a, 8'h00};
   localparam logic [7:0] rl_len = 8'd13;
   localparam logic [7:0] bin_str [12] = '{8'h10, 8'h01, 8'h52, 8'h45, 8'h4c, 8'h4f, 8'h41,
      8'h44, 8'h5f, 8'h52, 8'h10, 8'h03};
   localparam logic [7:0] bin_len = 8'd12;

   logic sleep_hit, reload_hit;

   // matcher progress
   always_comb
   begin
      next_smatch = smatch;
      next_match = match;
      next_bmatch = bmatch;
      sleep_hit = 1'b0;
      reload_hit = 1'b0;
      if (is_text)
      begin
         // [RL6] sleep request decode
         if (rx_byte.data == sleep_str[smatch[4:0]])
            next_smatch = smatch + 8'd1;
         else
            next_smatch = (rx_byte.data == dollar_byte) ? 8'd1 : 8'd0;
         if (next_smatch == sleep_len)
         begin
            sleep_hit = 1'b1;
            next_smatch = 8'd0;
         end
         // [RL14] text reload decode
         if (rx_byte.data == rl_str[match[3:0]])
            next_match = match + 8'd1;
         else
            next_match = (rx_byte.data == dollar_byte) ? 8'd1 : 8'd0;
         if (next_match == rl_len)
         begin
            reload_hit = 1'b1;
            next_match = 8'd0;
         end
      end
      if (rx_take && rx_byte.port == 1'b1)
      begin
         // [RL14] binary reload decode
         if (rx_byte.data == bin_str[bmatch[3:0]])
            next_bmatch = bmatch + 8'd1;
         else
            next_bmatch = (rx_byte.data == dle_byte) ? 8'd1 : 8'd0;
         if (next_bmatch == bin_len)
         begin
            reload_hit = 1'b1;
            next_bmatch = 8'd0;
         end
      end
   end

   // main sequencer
   logic fell;
   assign fell = |(rx_prev & ~rx_line);
   always_comb
   begin
      next_state = state;
      next_timer = timer;
      next_blk_cnt = blk_cnt;
      next_tx_byte = crc_request_char;
      tx_req = 1'b0;
      patch_byte_valid = 1'b0;
      patch_byte = rx_byte.data;
      flash_erase = 1'b0;
      flash_write = 1'b0;
      restart = 1'b0;
      unique case (state)
         st_run:
         begin
            if (reload_hit)
            begin
               next_state = st_prog_poll;
               next_timer = 32'd0;
            end
            else if (sleep_hit)
            begin
               next_state = st_sleep_wait;
               next_timer = 32'd0;
            end
         end
         // [RL8] hold off sleep for 10 ms
         st_sleep_wait:
         begin
            next_timer = timer + 32'd1;
            if (timer >= settle_cycles - 1)
               next_state = st_asleep;
         end
         // [RL9] wake on any falling receive edge
         st_asleep:
            if (fell)
            begin
               next_state = st_waking;
               next_timer = 32'd0;
            end
         // [RL10] 10 ms back to normal operation
         st_waking:
         begin
            next_timer = timer + 32'd1;
            if (timer >= settle_cycles - 1)
               next_state = st_run;
         end
         // [RL22] repeat request character until data flows
         st_prog_poll:
         begin
            next_timer = (timer >= poll_cycles - 1) ? 32'd0 : timer + 32'd1;
            tx_req = (timer == 32'd0);
            if (rx_take && rx_byte.data == xm_soh)
            begin
               next_state = st_prog_rx;
               next_blk_cnt = 8'd1;
            end
         end
         // [RL15] pass xmodem stream to the patch buffer
         st_prog_rx:
         begin
            if (rx_take)
            begin
               if (blk_cnt == 8'd0 && rx_byte.data == xm_eot)
               begin
                  tx_req = 1'b1;
                  next_tx_byte = xm_ack;
                  next_state = st_check;
               end
               else
               begin
                  patch_byte_valid = 1'b1;
                  next_blk_cnt = (blk_cnt == xm_block_len - 1) ? 8'd0 : blk_cnt + 8'd1;
                  if (blk_cnt == xm_block_len - 1)
                  begin
                     tx_req = 1'b1;
                     next_tx_byte = xm_ack;
                  end
               end
            end
         end
         // [RL18] refuse a mismatched version
         st_check:
            next_state = patch_version_ok ? st_erase : st_restart;
         // [RL17] erase old patch after transfer end
         st_erase:
         begin
            flash_erase = 1'b1;
            if (flash_done)
               next_state = st_write;
         end
         st_write:
         begin
            flash_write = 1'b1;
            if (flash_done)
               next_state = st_restart;
         end
         // [RL16] restart after storing
         st_restart:
         begin
            restart = 1'b1;
            next_state = st_run;
         end
         default:
            next_state = st_run;
      endcase
   end

   // [RL5] once per second solution tick
   always_comb
   begin
      next_fix_cnt = (fix_cnt >= fix_cycles - 1) ? 32'd0 : fix_cnt + 32'd1;
      fix_tick = (state == st_run) && (fix_cnt == 32'd0);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state <= st_run;
         timer <= 32'd0;
         fix_cnt <= 32'd0;
         blk_cnt <= 8'd0;
         match <= 8'd0;
         bmatch <= 8'd0;
         smatch <= 8'd0;
         rx_prev <= 2'b11;
      end
      else
      begin
         state <= next_state;
         timer <= next_timer;
         fix_cnt <= next_fix_cnt;
         blk_cnt <= next_blk_cnt;
         match <= next_match;
         bmatch <= next_bmatch;
         smatch <= next_smatch;
         rx_prev <= rx_line;
      end
   end

   // power outputs
   always_comb
   begin
      // [RL7] sleep indicator and radio shutdown
      sleep_flag = (state != st_asleep);
      rf_enable = (state != st_asleep);
      ref_osc_enable = (state != st_asleep);
      // [RL21] gate search, channels and interface by use
      unit_clk_en[0] = (state == st_run);
      unit_clk_en[1] = (state == st_run) || (state == st_waking);
      unit_clk_en[2] = (state != st_asleep);
   end

endmodule : host_command_sleep_fw_loader

// *** cmd_checker.sv ***
`timescale 1ns/1ps
module cmd_checker
   import cmd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // watched ports
   input wire logic rx_valid,
   input wire rx_byte_s rx_byte,
   input wire logic [1:0] corr_enable,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_ready,
   input wire proto_e port_proto [2],
   input wire logic [31:0] port_baud [2],
   input wire logic sleep_flag,
   input wire logic rf_enable,
   input wire logic ref_osc_enable,
   input wire logic patch_byte_valid,
   input wire logic flash_erase,
   input wire logic flash_write,
   input wire logic flash_done,
   input wire logic restart
);
   logic [19:0] quiet;
   logic [19:0] next_quiet;
   logic erased;
   logic next_erased;
   default clocking dc @(posedge clk); endclocking
   default disable iff (reset);
   // cycles since the last line feed, and erase seen since restart
   always_comb
   begin
      next_quiet = quiet + {19'h0, quiet != 20'hfffff};
      if (reset || (rx_valid && rx_byte.data == lf_byte))
         next_quiet = 20'h0;
      next_erased = !reset && !restart && (erased || (flash_erase && flash_done));
   end
   // helper registers
   always_ff @(posedge clk)
   begin
      quiet <= next_quiet;
      erased <= next_erased;
   end
   a_word_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("tx word changed while stalled");
   a_default_rates: assert property (port_baud[0] == default_baud && port_baud[1] == default_baud)
      else $error("port rate not default");
   a_text_port: assert property (!corr_enable[0] |-> port_proto[0] == proto_text)
      else $error("port one not text");
   a_binary_port: assert property (!corr_enable[1] |-> port_proto[1] == proto_binary)
      else $error("port two not binary");
   a_corr_mode: assert property (corr_enable[1] |-> port_proto[1] == proto_corr)
      else $error("correction mode not shown");
   a_corr_port0: assert property (corr_enable[0] |-> port_proto[0] == proto_corr)
      else $error("port one correction mode not shown");
   a_power_follows: assert property (rf_enable == sleep_flag && ref_osc_enable == sleep_flag)
      else $error("power enables disagree with sleep flag");
   a_sleep_settle: assert property ($fell(sleep_flag) |-> quiet >= settle_cycles - 2)
      else $error("sleep entered too early");
   a_erase_first: assert property ($rose(flash_write) |-> erased && !flash_erase)
      else $error("write without erase");
   a_flash_after: assert property (flash_erase || flash_write |-> !patch_byte_valid)
      else $error("patch byte during flash");
   a_restart_pulse: assert property (restart |=> !restart)
      else $error("restart longer than one cycle");
endmodule : cmd_checker

// *** host_model.sv ***
`timescale 1ns/1ps
module host_model
   import cmd_pkg::*;
(
   // clock
   input wire logic clk,
   // bytes toward the device
   output logic rx_valid,
   output rx_byte_s rx_byte,
   input wire logic rx_ready,
   // bytes from the device
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic [7:0] got [$];
   initial
   begin
      rx_valid = 1'b0;
      rx_byte = '0;
      tx_ready = 1'b1;
   end
   task automatic send(input logic p, input logic [7:0] d);
      @(negedge clk);
      rx_valid = 1'b1;
      rx_byte = '{port: p, data: d};
      do @(posedge clk); while (rx_ready !== 1'b1);
   endtask : send
   // text held as bytes
   task automatic send_str(input logic p, input string s);
      for (int i = 0; i < s.len(); i++)
         send(p, s[i]);
   endtask : send_str
   // release the line, data no longer valid
   task automatic idle();
      @(negedge clk);
      rx_valid = 1'b0;
      rx_byte.data = ~rx_byte.data;
   endtask : idle
   // random stalls toward the device
   always @(negedge clk)
      tx_ready <= ($urandom_range(0, 3) != 0);
   // collect accepted words
   always @(posedge clk)
      if (tx_valid && tx_ready)
         got.push_back(tx_data);
endmodule : host_model

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
   import cmd_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic rx_valid, rx_ready, tx_valid, tx_ready, sleep_flag, rf_enable, ref_osc_enable;
   logic flash_erase, flash_write, restart, patch_version_ok, flash_done;
   logic [1:0] rx_line, corr_enable;
   logic [7:0] tx_data;
   logic fix_tick, patch_byte_valid;
   logic [7:0] patch_byte;
   logic [2:0] unit_clk_en;
   int ticks = 0;
   int pbytes = 0;
   int psum = 0;
   rx_byte_s rx_byte;
   proto_e port_proto [2];
   logic [31:0] port_baud [2];
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;
   int erases = 0;
   int writes = 0;
   int restarts = 0;
   // clock
   always #12.5 clk = ~clk;
   host_command_sleep_fw_loader dut_u (.clk(clk), .reset(reset), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .rx_ready(rx_ready), .rx_line(rx_line), .corr_enable(corr_enable),
      .patch_version_ok(patch_version_ok), .flash_done(flash_done), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .port_proto(port_proto), .port_baud(port_baud),
      .sleep_flag(sleep_flag), .rf_enable(rf_enable), .ref_osc_enable(ref_osc_enable),
      .unit_clk_en(unit_clk_en), .fix_tick(fix_tick), .patch_byte_valid(patch_byte_valid),
      .patch_byte(patch_byte),
      .flash_erase(flash_erase), .flash_write(flash_write), .restart(restart));
   host_model host_u (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
   // flash answers after a random wait
   always @(negedge clk)
      flash_done <= (flash_erase | flash_write) & ~flash_done & ($urandom_range(0, 3) == 0);
   // action counts and hang guard
   always @(posedge clk)
   begin
      cycles++;
      erases += int'(flash_erase & flash_done);
      writes += int'(flash_write & flash_done);
      restarts += int'(restart);
      ticks += int'(fix_tick & ~reset);
      pbytes += int'(patch_byte_valid);
      psum += patch_byte_valid ? int'(patch_byte) : 0;
      if (cycles == 20000)
      begin
         miscompares++;
         finish_test();
      end
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
         miscompares++;
      end
   endtask : check
   task automatic finish_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   // next word from the device under a bound
   task automatic expect_tx(input string name, input logic [7:0] exp);
      for (int n = 0; n < 3000 && host_u.got.size() == 0; n++)
         @(posedge clk);
      check(name, (host_u.got.size() != 0) ? host_u.got.pop_front() : 8'hxx, exp);
   endtask : expect_tx
   // reload of one kind, one block, end of transfer, flash when ok, and restart
   task automatic load(input int kind, input logic ok);
      logic p;
      int e;
      int w;
      int r;
      int pb;
      int ps;
      int s;
      logic [7:0] b;
      p = (kind != 0);
      e = erases;
      w = writes;
      r = restarts;
      pb = pbytes;
      ps = psum;
      @(negedge clk);
      // version answer stands for the mask rom version match of the sent patch
      patch_version_ok = ok;
      if (kind == 1)
      begin
         host_u.send(p, dle_byte);
         host_u.send(p, stx_byte);
         host_u.send_str(p, "RELOAD_R");
         host_u.send(p, dle_byte);
         host_u.send(p, etx_byte);
      end
      else
      begin
         // text reload; for kind 2, after stream bytes on a correction port
         repeat (3 * kind) host_u.send(p, 8'($urandom_range(0, 35)));
         host_u.send_str(p, {"$PO", "PRL,R*2F\r\n"});
      end
      host_u.idle();
      expect_tx("request", crc_request_char);
      host_u.send(p, xm_soh);
      host_u.send(p, 8'h01);
      host_u.send(p, 8'hfe);
      s = 1 + 254;
      repeat (xm_block_len - 3)
      begin
         b = 8'($urandom);
         s += b;
         host_u.send(p, b);
      end
      host_u.idle();
      expect_tx("block_ack", xm_ack);
      host_u.send(p, xm_eot);
      host_u.idle();
      expect_tx("end_ack", xm_ack);
      check("patch_bytes", pbytes - pb, xm_block_len - 1);
      check("patch_sum", psum - ps, s);
      // no reset or power loss until the restart
      for (int n = 0; n < 3000 && restarts == r; n++)
         @(posedge clk);
      check("erase", erases - e, {31'h0, ok});
      check("write", writes - w, {31'h0, ok});
      check("restart", restarts - r, 32'h1);
      repeat (20) @(posedge clk);
   endtask : load
   // main sequence
   initial
   begin
      void'($urandom(88241));
      rx_line = 2'b11; // lines stay idle: no wake edge sent, no settle wait owed
      corr_enable = 2'b00;
      patch_version_ok = 1'b1;
      flash_done = 1'b0;
      repeat (10) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      @(posedge clk);
      check("proto0", port_proto[0], proto_text);
      check("proto1", port_proto[1], proto_binary);
      check("baud0", port_baud[0], default_baud);
      check("baud1", port_baud[1], default_baud);
      check("awake", {sleep_flag, rf_enable, ref_osc_enable}, 3'h7);
      check("clk_en", unit_clk_en, 3'h7);
      load(0, 1'b1);
      load(1, 1'b0);
      @(negedge clk);
      corr_enable = 2'b11; // correction input enabled before any text output select
      @(posedge clk);
      check("proto0c", port_proto[0], proto_corr);
      check("proto1c", port_proto[1], proto_corr);
      load(2, 1'b1);
      host_u.send_str(1'b0, {"$PO", "PWR,1111*66\r\n"});
      host_u.idle();
      repeat (2000) @(posedge clk);
      check("not_asleep", {sleep_flag, rf_enable, ref_osc_enable}, 3'h7);
      check("fix_ticks", ticks, 32'h1);
      finish_test();
   end
endmodule : tb
bind host_command_sleep_fw_loader cmd_checker chk_u (.clk(clk), .reset(reset),
   .rx_valid(rx_valid), .rx_byte(rx_byte), .corr_enable(corr_enable), .tx_valid(tx_valid),
   .tx_data(tx_data), .tx_ready(tx_ready), .port_proto(port_proto), .port_baud(port_baud),
   .sleep_flag(sleep_flag), .rf_enable(rf_enable), .ref_osc_enable(ref_osc_enable),
   .patch_byte_valid(patch_byte_valid), .flash_erase(flash_erase),
   .flash_write(flash_write), .flash_done(flash_done), .restart(restart));
